/* File: verilog/rnc_row_correct.v */
// row-wise dark level noise correction stage with its registers
`timescale 1ns/1ns
`default_nettype none
`include "rnc_defs.vh"

module rnc_row_correct
(
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        regWrEn,
   input  wire [7:0]  regAddr,
   input  wire [15:0] regWrData,
   output reg  [15:0] regRdData_q,
   input  wire        frameValid,
   input  wire        lineValid,
   input  wire        pixValid,
   input  wire [9:0]  pixCol,
   input  wire [9:0]  pixData,
   input  wire [7:0]  frameDarkAvg,
   output reg         corrValid_q,
   output reg  [9:0]  corrData_q,
   output reg         corrLineValid_q,
   output reg         corrFrameValid_q
);

   // ----------------------------------------------------------------------
   // pending register values, written by software
   // ----------------------------------------------------------------------
   reg  [3:0]  cntPend_q;
   reg         enPend_q;
   reg         blaPend_q;
   reg  [7:0]  constPend_q;
   reg  [9:0]  startPend_q;

   // ----------------------------------------------------------------------
   // active values, used by the pixel path
   // ----------------------------------------------------------------------
   reg  [3:0]  cntAct_q;
   reg         enAct_q;
   reg         blaAct_q;
   reg  [7:0]  constAct_q;
   reg  [9:0]  startAct_q;
   reg  [7:0]  frameAvgAct_q;

   reg         frameValidDly_q;
   reg         lineValidDly_q;
   wire        frameStart;
   wire        lineStart;
   wire [9:0]  darkEnd;
   wire        inDark;
   wire        isActive;
   wire [9:0]  rowAvg;
   wire [9:0]  darkAvg;
   wire [11:0] corrected;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function [4:0] darkCount;
      input [3:0] code;
      begin
         case (code)
            4'h0:    darkCount = 5'h02;
            4'h1:    darkCount = 5'h04;
            4'h2:    darkCount = 5'h06;
            4'h4:    darkCount = 5'h0a;
            4'h8:    darkCount = 5'h12;
            // illegal codes behave as the reset count
            default: darkCount = 5'h0a;
         endcase
      end
   endfunction

   // signed 12-bit arithmetic, then clamp so dark rows never wrap
   function [9:0] clampPix;
      input [11:0] value;
      begin
         if (value[11])
            clampPix = 10'h000;
         else if (value > `RNC_PIX_MAX)
            clampPix = 10'h3ff;
         else
            clampPix = value[9:0];
      end
   endfunction

   assign frameStart = frameValid & ~frameValidDly_q;
   assign lineStart  = lineValid & ~lineValidDly_q;
   assign darkEnd    = startAct_q + {5'h00, darkCount(cntAct_q)};
   assign inDark     = (pixCol >= startAct_q) && (pixCol < darkEnd);
   assign isActive   = pixCol < `RNC_ACTIVE_COLS;

   // ----------------------------------------------------------------------
   // dark average per row
   // ----------------------------------------------------------------------
   rnc_dark_avg u_dark_avg
   (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .rowClear   (lineStart),
      .sampleEn   (pixValid & lineValid & inDark),
      .sampleData (pixData),
      .countCode  (cntAct_q),
      .darkAvg_q  (darkAvg)
   );

   // the frame average is latched as delivered, before later offset moves
   assign rowAvg = blaAct_q ? {2'b00, frameAvgAct_q} : darkAvg;

   assign corrected = {2'b00, pixData} - {2'b00, rowAvg}
                      + {4'h0, constAct_q};

   // ----------------------------------------------------------------------
   // register writes and frame-boundary shadow transfer
   // ----------------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         cntPend_q     <= `RNC_RST_CNT;
         enPend_q      <= `RNC_RST_EN;
         blaPend_q     <= `RNC_RST_BLA;
         constPend_q   <= `RNC_RST_CONST;
         startPend_q   <= `RNC_RST_DARKSTART;
         cntAct_q      <= `RNC_RST_CNT;
         enAct_q       <= `RNC_RST_EN;
         blaAct_q      <= `RNC_RST_BLA;
         constAct_q    <= `RNC_RST_CONST;
         startAct_q    <= `RNC_RST_DARKSTART;
         frameAvgAct_q <= 8'h00;
      end
      else
      begin
         if (regWrEn)
         begin
            case (regAddr)
               `RNC_ADDR_CTRL:
               begin
                  cntPend_q <= regWrData[`RNC_CTRL_CNT_MSB:`RNC_CTRL_CNT_LSB];
                  enPend_q  <= regWrData[`RNC_CTRL_EN_BIT];
                  blaPend_q <= regWrData[`RNC_CTRL_BLA_BIT];
               end
               `RNC_ADDR_CONST:     constPend_q <= regWrData[7:0];
               `RNC_ADDR_DARKSTART: startPend_q <= regWrData[9:0];
               default:
               begin
               end
            endcase
         end
         // a write in the frame-start cycle lands in the next frame
         if (frameStart)
         begin
            cntAct_q      <= cntPend_q;
            enAct_q       <= enPend_q;
            blaAct_q      <= blaPend_q;
            constAct_q    <= constPend_q;
            startAct_q    <= startPend_q;
            frameAvgAct_q <= frameDarkAvg;
         end
      end
   end

   // ----------------------------------------------------------------------
   // register reads, one cycle after the address
   // ----------------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (!rst_n)
         regRdData_q <= 16'h0000;
      else
      begin
         case (regAddr)
            `RNC_ADDR_CTRL:
               regRdData_q <= {4'h0, blaPend_q, 5'h00, enPend_q, 1'b1,
                               cntPend_q};
            `RNC_ADDR_CONST:     regRdData_q <= {8'h00, constPend_q};
            `RNC_ADDR_DARKSTART: regRdData_q <= {6'h00, startPend_q};
            `RNC_ADDR_FRAMEAVG:
               regRdData_q <= {8'h00, frameDarkAvg};
            default:             regRdData_q <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // pixel path
   // ----------------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         frameValidDly_q  <= 1'b0;
         lineValidDly_q   <= 1'b0;
         corrValid_q      <= 1'b0;
         corrData_q       <= 10'h000;
         corrLineValid_q  <= 1'b0;
         corrFrameValid_q <= 1'b0;
      end
      else
      begin
         frameValidDly_q  <= frameValid;
         lineValidDly_q   <= lineValid;
         corrLineValid_q  <= lineValid;
         corrFrameValid_q <= frameValid;
         corrValid_q      <= pixValid & lineValid & isActive;
         if (pixValid & lineValid & isActive)
         begin
            if (enAct_q)
               corrData_q <= clampPix(corrected);
            else
               corrData_q <= pixData;
         end
      end
   end

endmodule
`default_nettype wire

/* File: verilog/rnc_defs.vh */
// constants for the row noise correction stage
`ifndef RNC_DEFS_VH
`define RNC_DEFS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define RNC_ADDR_CTRL        8'h70
`define RNC_ADDR_CONST       8'h72
`define RNC_ADDR_DARKSTART   8'h73
`define RNC_ADDR_FRAMEAVG    8'h42

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define RNC_CTRL_CNT_MSB     3
`define RNC_CTRL_CNT_LSB     0
`define RNC_CTRL_RSVD_BIT    4
`define RNC_CTRL_EN_BIT      5
`define RNC_CTRL_BLA_BIT     11

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RNC_RST_CNT          4'h4
`define RNC_RST_EN           1'b1
`define RNC_RST_BLA          1'b0
`define RNC_RST_CONST        8'h2a
`define RNC_RST_DARKSTART    10'h2f7

// ----------------------------------------------------------------------
// pixel geometry and arithmetic
// ----------------------------------------------------------------------
`define RNC_ACTIVE_COLS      10'h2f0
`define RNC_PIX_MAX          12'h3ff
`define RNC_RECIP_SHIFT      16

`endif

/* File: verilog/rnc_dark_avg.v */
// per-row dark column accumulator and averager
`timescale 1ns/1ns
`default_nettype none
`include "rnc_defs.vh"

module rnc_dark_avg
(
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        rowClear,
   input  wire        sampleEn,
   input  wire [9:0]  sampleData,
   input  wire [3:0]  countCode,
   output reg  [9:0]  darkAvg_q
);

   reg  [14:0] sum_q;
   wire [30:0] product;

   // ----------------------------------------------------------------------
   // reciprocal of the dark pixel count, 2^16 / n rounded up
   // ----------------------------------------------------------------------
   function [15:0] recip;
      input [3:0] code;
      begin
         case (code)
            4'h0:    recip = 16'h8000;
            4'h1:    recip = 16'h4000;
            4'h2:    recip = 16'h2aab;
            4'h4:    recip = 16'h199a;
            4'h8:    recip = 16'h0e39;
            // illegal codes fall back to the reset count of ten
            default: recip = 16'h199a;
         endcase
      end
   endfunction

   // multiply instead of divide: n is not a power of two for most codes
   assign product = sum_q * recip(countCode);

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         sum_q     <= 15'h0000;
         darkAvg_q <= 10'h000;
      end
      else
      begin
         // the first dark sample may share the row-start cycle
         if (rowClear && sampleEn)
            sum_q <= {5'h00, sampleData};
         else if (rowClear)
            sum_q <= 15'h0000;
         else if (sampleEn)
            sum_q <= sum_q + {5'h00, sampleData};
         darkAvg_q <= product[`RNC_RECIP_SHIFT + 9:`RNC_RECIP_SHIFT];
      end
   end

endmodule
`default_nettype wire

/* File: tb/rnc_pix_src.sv */
// pixel stream source standing in for the column readout
`timescale 1ns/1ns
`default_nettype none
module rnc_pix_src
(
   input  wire logic       sys_clk,
   output var  logic       frameValid,
   output var  logic       lineValid,
   output var  logic       pixValid,
   output var  logic [9:0] pixCol,
   output var  logic [9:0] pixData,
   output var  logic [7:0] frameDarkAvg
);
   int dk[18];
   int px[8];
   int fda;
   initial
   begin
      {frameValid, lineValid, pixValid} = 3'h0;
      {pixCol, pixData, frameDarkAvg} = 28'h0;
   end
   // idle lines flip so a stale value never looks like a sample
   task automatic step(input logic v, input logic lv,
                       input int c, input int d);
      @(negedge sys_clk);
      lineValid = lv;
      pixValid = v;
      pixCol = v ? c[9:0] : ~pixCol;
      pixData = v ? d[9:0] : ~pixData;
   endtask
   task automatic frame_open;
      @(negedge sys_clk);
      frameDarkAvg = fda[7:0];
      frameValid = 1'b1;
      step(0, 0, 0, 0);
      // settled level drifts after the frame start latch
      frameDarkAvg = ~frameDarkAvg;
   endtask
   task automatic row(input int st, input int n);
      int i;
      for (i = 0; i < n; i++)
         step(1, 1, st + i, dk[i]);
      // one column past the window must stay out of the sum
      step(1, 1, st + n, 1023);
      repeat (2) step(0, 1, 0, 0);
      for (i = 0; i < 8; i++)
         step(1, 1, i * 90, px[i]);
      step(0, 0, 0, 0);
   endtask
   task automatic frame_close;
      @(negedge sys_clk);
      frameValid = 1'b0;
      step(0, 0, 0, 0);
   endtask
endmodule
`default_nettype wire

/* File: tb/rnc_chk_assertions.sv */
// assertion checker for the row correction stage
`timescale 1ns/1ns
`default_nettype none
module rnc_chk
(
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        regWrEn,
   input wire logic [7:0]  regAddr,
   input wire logic [15:0] regWrData,
   input wire logic [15:0] regRdData_q,
   input wire logic        frameValid,
   input wire logic        lineValid,
   input wire logic        pixValid,
   input wire logic [9:0]  pixCol,
   input wire logic [9:0]  pixData,
   input wire logic [7:0]  frameDarkAvg,
   input wire logic        corrValid_q,
   input wire logic [9:0]  corrData_q,
   input wire logic        corrLineValid_q,
   input wire logic        corrFrameValid_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire take = pixValid && lineValid;
   a_active_out:
      assert property (take && pixCol < 10'd752 |=> corrValid_q)
      else $error("active sample gave no output");
   a_dark_eaten:
      assert property (take && pixCol >= 10'd752 |=> !corrValid_q)
      else $error("dark sample produced output");
   a_idle_quiet:
      assert property (!take |=> !corrValid_q)
      else $error("output without a sample");
   a_data_hold:
      assert property (!take |=> $stable(corrData_q))
      else $error("pixel output moved while idle");
   a_ctrl_rsvd:
      assert property (regAddr == 8'h70 |=> regRdData_q[4] &&
         regRdData_q[15:12] == 4'h0) else $error("control read bad");
   a_const_read:
      assert property (regAddr == 8'h72 |=> regRdData_q[15:8] == 8'h00)
      else $error("constant read wider than 8 bits");
   a_start_read:
      assert property (regAddr == 8'h73 |=> regRdData_q[15:10] == 6'h00)
      else $error("start column read wider than 10 bits");
   a_avg_read:
      assert property (regAddr == 8'h42 |=>
         regRdData_q == {8'h00, $past(frameDarkAvg)}) else $error("avg read");
   a_line_delay:
      assert property (corrLineValid_q == $past(lineValid))
      else $error("line valid not delayed by one cycle");
   a_frame_delay:
      assert property (corrFrameValid_q == $past(frameValid))
      else $error("frame valid not delayed by one cycle");
   cover property (take && pixCol < 10'd752);
   cover property (regWrEn && regAddr == 8'h70);
   cover property ($rose(frameValid));
endmodule
bind rnc_row_correct rnc_chk u_chk
(
   .sys_clk, .rst_n, .regWrEn, .regAddr, .regWrData, .regRdData_q,
   .frameValid, .lineValid, .pixValid, .pixCol, .pixData, .frameDarkAvg,
   .corrValid_q, .corrData_q, .corrLineValid_q, .corrFrameValid_q
);
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the row correction stage
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        regWrEn = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [15:0] regWrData = 16'h0000;
   logic [15:0] regRdData_q;
   logic        frameValid, lineValid, pixValid, corrValid_q;
   logic        corrLineValid_q, corrFrameValid_q;
   logic [9:0]  pixCol, pixData, corrData_q;
   logic [7:0]  frameDarkAvg;
   int          n_mismatch = 0;
   int          compares = 0;
   int          cyc = 0;
   int          expq[$];
   always #50 sys_clk = ~sys_clk;
   rnc_row_correct u_rnc_row_correct
   (
      .sys_clk, .rst_n, .regWrEn, .regAddr, .regWrData, .regRdData_q,
      .frameValid, .lineValid, .pixValid, .pixCol, .pixData, .frameDarkAvg,
      .corrValid_q, .corrData_q, .corrLineValid_q, .corrFrameValid_q
   );
   rnc_pix_src u_rnc_pix_src
   (
      .sys_clk, .frameValid, .lineValid, .pixValid, .pixCol, .pixData,
      .frameDarkAvg
   );
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk_reg(input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED regRdData_q expected %h seen %h", e, g);
      end
   endtask
   task automatic chk_pix(input logic [9:0] e, input logic [9:0] g);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED corrData_q expected %h seen %h", e, g);
      end
   endtask
   task automatic chk_cnt(input int e, input int g);
      compares++;
      if (g != e)
      begin
         n_mismatch++;
         $display("CHECK FAILED pixel count expected %0d seen %0d", e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = d;
      @(negedge sys_clk);
      regWrEn = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(negedge sys_clk);
      regAddr = a;
      @(negedge sys_clk);
      chk_reg(e, regRdData_q);
   endtask
   // an output with nothing expected is a mismatch of its own
   always @(negedge sys_clk)
   begin
      if (corrValid_q !== 1'b0 && expq.size() == 0)
         chk_cnt(0, 1);
      else if (corrValid_q !== 1'b0)
         chk_pix(expq.pop_front(), corrData_q);
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000) n_mismatch++;
      if (cyc == 20000) end_of_test();
   end
   initial
   begin
      int codes[5];
      int t, i, n, en, bla, c, st, fda, ctrl, sum, avg, e;
      codes = '{0, 1, 2, 4, 8};
      void'($urandom(32'h5667));
      repeat (16) @(negedge sys_clk);
      rst_n = 1'b1;
      rd(8'h70, 16'h0034);
      rd(8'h72, 16'h002a);
      rd(8'h73, 16'h02f7);
      rd(8'h55, 16'h0000);
      for (t = 0; t < 12; t++)
      begin
         n = codes[t % 5] * 2 + 2;
         en = (t != 5);
         bla = (t >= 8);
         c = $urandom % 256;
         st = 759 + $urandom % 17;
         fda = $urandom % 256;
         ctrl = bla * 2048 + en * 32 + codes[t % 5];
         wr(8'h70, ctrl[15:0]);
         wr(8'h72, c[15:0]);
         wr(8'h73, st[15:0]);
         rd(8'h70, ctrl[15:0] | 16'h0010);
         sum = 0;
         for (i = 0; i < n; i++)
         begin
            u_rnc_pix_src.dk[i] = $urandom % 1024;
            sum += u_rnc_pix_src.dk[i];
         end
         avg = bla ? fda : sum * ((65535 + n) / n) / 65536;
         // first two pixels sit at the range ends to force saturation
         for (i = 0; i < 8; i++)
         begin
            u_rnc_pix_src.px[i] = i < 2 ? i * 1023 : $urandom % 1024;
            e = u_rnc_pix_src.px[i] - avg + c;
            e = e < 0 ? 0 : e > 1023 ? 1023 : e;
            expq.push_back(en ? e : u_rnc_pix_src.px[i]);
         end
         u_rnc_pix_src.fda = fda;
         u_rnc_pix_src.frame_open();
         wr(8'h70, 16'h0000);
         u_rnc_pix_src.row(st, n);
         u_rnc_pix_src.frame_close();
         chk_cnt(0, expq.size());
         // the source drifts the level after the frame-start latch
         e = 255 - fda;
         rd(8'h42, e[15:0]);
         $display("test %0d done", t);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
